// File: hdl/uere_engine.sv
// usb endpoint response engine with wishbone register access
`timescale 1ns/100ps
`include "uere_cfg.svh"
module uere_engine import uere_pkg::*; #(
	parameter int EP_NUM  = 2,
	parameter int EP_SIZE = 8
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// link side from packet decoder
	input  wire logic        tok_stb_i,
	input  wire uere_tok_s   tok_i,
	input  wire logic        data_start_i,
	input  wire logic        data_end_i,
	input  wire uere_dat_s   dat_rx_i,
	input  wire logic        in_end_i,
	input  wire logic        in_ack_i,
	// response to packet encoder
	output logic             resp_stb_o,
	output uere_resp_s       resp_o,
	// interrupt
	output logic             irq_o
);
	logic [3:0]        mode_r  [EP_NUM];
	logic [EP_NUM-1:0] stall_r, ack_r, out_r, in_r, setup_r, dval_r, data_toggle_flag_r;
	logic [6:0]        cnt_r   [EP_NUM];
	logic [EP_NUM-1:0] ist_r, imask_r;
	logic              lock_r, wb_ack_r, resp_stb_r, irq_r;
	logic [31:0]       rdat_r;
	uere_resp_s        resp_r;
	uere_state_e       st_r, st_nxt;
	uere_pid_e         pid_r;
	logic [3:0]        ep_r;
	logic [7:0]        busy_cnt_r;
	// decision outputs for the current event
	logic              upd, setup_set, take_data, dv_new, int_set;
	logic              set_ack, set_in, set_out;
	logic [3:0]        mode_new;
	uere_resp_e        rcode;
	logic              resp_now;
	logic [3:0]        m;
	logic              stl, tok_go, dvalid, ep_ok;
	localparam logic [7:0] LOCK_CYC = 8'(`UERE_LOCK_CYC);
	localparam int         MAX_CNT  = EP_SIZE + `UERE_CRC_BYTES;

	// wishbone decode
	logic       wb_req, in_map, is_mode, is_cnt, is_ist, is_imask;
	logic [3:0] wb_ep;
	logic       ep0_wr_block;
	assign wb_req   = cyc_i & stb_i & ~wb_ack_r;
	assign wb_ep    = adr_i[6:3];
	assign in_map   = 32'(wb_ep) < EP_NUM && !adr_i[7] && adr_i[1:0] == 2'h0;
	assign is_mode  = in_map && adr_i[2] == 1'b0;
	assign is_cnt   = in_map && adr_i[2] == 1'b1;
	assign is_ist   = adr_i == `UERE_INT_STAT;
	assign is_imask = adr_i == `UERE_INT_MASK;
	// endpoint 0 refuses writes while locked or an endpoint 0 transaction is in flight
	assign ep0_wr_block = lock_r || (st_r != UERE_ST_IDLE && ep_r == 4'h0);

	// event decode; ep index of the active or arriving transaction
	assign ep_ok  = 32'(tok_i.ep) < EP_NUM;
	assign tok_go = tok_stb_i && tok_i.ok && ep_ok && st_r == UERE_ST_IDLE;
	assign m      = mode_r[tok_go ? tok_i.ep[0 +: $clog2(EP_NUM)] :
		ep_r[0 +: $clog2(EP_NUM)]];
	assign stl    = stall_r[tok_go ? tok_i.ep[0 +: $clog2(EP_NUM)] :
		ep_r[0 +: $clog2(EP_NUM)]];
	assign dvalid = dat_rx_i.crc_ok && dat_rx_i.err_ok &&
		32'(dat_rx_i.cnt) <= MAX_CNT;

	// response decision per mode and token
	always_comb begin
		upd = 1'b0; setup_set = 1'b0; take_data = 1'b0; dv_new = 1'b0;
		int_set = 1'b0; set_ack = 1'b0; set_in = 1'b0; set_out = 1'b0;
		mode_new = m; rcode = UERE_R_NONE; resp_now = 1'b0;
		st_nxt = st_r;
		case (st_r)
		UERE_ST_IDLE: begin
			if (tok_go && tok_i.pid == UERE_PID_IN) begin
				resp_now = 1'b1;
				case (m)
				4'h1, 4'hc, 4'he: rcode = UERE_R_NAK;
				4'h2, 4'h3:       rcode = UERE_R_STALL;
				4'h6, 4'ha, 4'hb: rcode = UERE_R_TX0;
				4'h7, 4'hf:       rcode = UERE_R_TXCNT;
				4'hd:             rcode = stl ? UERE_R_STALL : UERE_R_TXCNT;
				default:          rcode = UERE_R_NONE;
				endcase
				if (m == 4'h2)
					mode_new = `UERE_MODE_STALL;
				if (rcode == UERE_R_TX0 || rcode == UERE_R_TXCNT)
					st_nxt = (m == 4'h7) ? UERE_ST_IDLE : UERE_ST_HS;
				upd     = rcode != UERE_R_NONE && st_nxt == UERE_ST_IDLE;
				set_in  = upd;
				int_set = upd && m != 4'hd;
			end else if (tok_go && tok_i.pid == UERE_PID_OUT) begin
				if (!(m == 4'h0 || m == 4'h4 || m == 4'h7 || m == 4'hc ||
					m == 4'hd))
					st_nxt = UERE_ST_DATA;
			end else if (tok_go) begin
				case (m)
				4'h0, 4'h5, 4'h7, 4'h8, 4'h9, 4'hc, 4'hd: st_nxt = st_r;
				default: st_nxt = UERE_ST_DATA;
				endcase
			end
		end
		UERE_ST_DATA: begin
			setup_set = data_start_i && pid_r == UERE_PID_SETUP;
			if (data_end_i) begin
				st_nxt = UERE_ST_IDLE;
				upd = 1'b1;
				resp_now = dvalid;
				if (pid_r == UERE_PID_SETUP) begin
					take_data = 1'b1; dv_new = dvalid; int_set = 1'b1;
					rcode = dvalid ? UERE_R_ACK : UERE_R_NONE;
					set_ack = dvalid;
					if (dvalid)
						mode_new = `UERE_MODE_NAKIO;
				end else begin
					set_out = 1'b1;
					case (m)
					4'h5, 4'hb, 4'h9: begin
						take_data = !(m == 4'h9 && stl); dv_new = dvalid;
						int_set = 1'b1;
						if (m == 4'h9 && stl) begin
							rcode = UERE_R_STALL; take_data = 1'b0;
						end else if (dvalid && m != 4'h5) begin
							rcode = UERE_R_ACK; set_ack = 1'b1;
							mode_new = {m[3:1], 1'b0};
						end
					end
					4'h2, 4'he, 4'hf: begin
						int_set = dvalid;
						set_out = dvalid;
						if (dvalid && 32'(dat_rx_i.cnt) == `UERE_ZLP_COUNT &&
							dat_rx_i.tog) begin
							rcode = UERE_R_ACK; set_ack = 1'b1;
						end else if (dvalid) begin
							rcode = UERE_R_STALL;
							mode_new = `UERE_MODE_STALL;
						end
					end
					4'h1, 4'h8, 4'ha: begin
						rcode = dvalid ? UERE_R_NAK : UERE_R_NONE;
						int_set = dvalid; set_out = dvalid;
					end
					4'h3, 4'h6: begin
						rcode = dvalid ? UERE_R_STALL : UERE_R_NONE;
						int_set = dvalid; set_out = dvalid;
						if (dvalid)
							mode_new = `UERE_MODE_STALL;
					end
					default: begin
						upd = 1'b0; set_out = 1'b0;
					end
					endcase
				end
			end
		end
		UERE_ST_HS: begin
			if (in_end_i) begin
				st_nxt = UERE_ST_IDLE;
				upd = 1'b1; set_in = 1'b1; int_set = 1'b1;
				set_ack = in_ack_i;
				if (in_ack_i && (m == 4'hd || m == 4'hf))
					mode_new = {m[3:1], 1'b0};
			end
		end
		default: st_nxt = UERE_ST_IDLE;
		endcase
	end

	// transaction state, a watchdog ends a transaction the link abandons
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= UERE_ST_IDLE; pid_r <= UERE_PID_OUT; ep_r <= 4'h0;
			busy_cnt_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			busy_cnt_r <= 8'h00;
			if (st_r != UERE_ST_IDLE) begin
				busy_cnt_r <= busy_cnt_r + 8'h01;
				// abandon: back to idle with the counter cleared at once
				if (busy_cnt_r == LOCK_CYC - 8'h01 &&
					st_nxt != UERE_ST_IDLE) begin
					st_r <= UERE_ST_IDLE;
					busy_cnt_r <= 8'h00;
				end
			end
			if (tok_go) begin
				pid_r <= tok_i.pid; ep_r <= tok_i.ep;
			end
		end
	end

	// response to the encoder
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_stb_r <= 1'b0; resp_r <= '0;
		end else begin
			resp_stb_r <= resp_now && rcode != UERE_R_NONE;
			// the response word stands until the next response
			if (resp_now && rcode != UERE_R_NONE) begin
				resp_r.code <= rcode;
				resp_r.cnt  <= rcode == UERE_R_TX0 ? 7'h00 :
					cnt_r[tok_i.ep[0 +: $clog2(EP_NUM)]];
				resp_r.tog  <= data_toggle_flag_r[tok_i.ep[0 +: $clog2(EP_NUM)]];
			end
		end
	end

	// endpoint registers: engine update wins over a cpu write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < EP_NUM; i++) begin
				mode_r[i] <= `UERE_MODE_RST;
				cnt_r[i]  <= 7'h00;
			end
			stall_r <= '0; ack_r <= '0; out_r <= '0; in_r <= '0;
			setup_r <= '0; dval_r <= '0; data_toggle_flag_r <= '0;
		end else begin
			for (int i = 0; i < EP_NUM; i++) begin
				if (wb_req && we_i && wb_ep == 4'(i) && sel_i[0] &&
					!(i == 0 && ep0_wr_block)) begin
					if (is_mode) begin
						mode_r[i] <= dat_i[3:0];
						ack_r[i] <= dat_i[`UERE_F_ACK];
						out_r[i] <= dat_i[`UERE_F_OUT];
						in_r[i] <= dat_i[`UERE_F_IN];
						setup_r[i] <= dat_i[`UERE_F_SETUP];
						if (sel_i[1])
							stall_r[i] <= dat_i[`UERE_F_STALL];
					end else if (is_cnt) begin
						cnt_r[i] <= dat_i[6:0] & 7'h3f;
						dval_r[i] <= dat_i[`UERE_F_DVAL];
						data_toggle_flag_r[i] <= dat_i[`UERE_F_DATA_TOGGLE_FLAG];
					end
				end
				if (setup_set && ep_r == 4'(i))
					setup_r[i] <= 1'b1;
				if (upd && ep_r == 4'(i) && st_r != UERE_ST_IDLE ||
					upd && tok_go && tok_i.ep == 4'(i)) begin
					mode_r[i] <= mode_new;
					if (set_ack) ack_r[i] <= 1'b1;
					if (set_in) in_r[i] <= 1'b1;
					if (set_out) out_r[i] <= 1'b1;
					if (take_data) begin
						cnt_r[i] <= dat_rx_i.cnt;
						dval_r[i] <= dv_new;
						data_toggle_flag_r[i] <= dat_rx_i.tog;
					end
				end
			end
		end
	end

	// endpoint 0 lock: set at update on ack or mode change, read clears
	logic ep0_upd;
	assign ep0_upd = upd && (tok_go ? tok_i.ep : ep_r) == 4'h0 &&
		(set_ack || mode_new != m);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lock_r <= 1'b0;
		else if (ep0_upd)
			lock_r <= 1'b1;
		else if (wb_req && !we_i && wb_ep == 4'h0 && (is_mode || is_cnt) &&
			st_r == UERE_ST_IDLE)
			lock_r <= 1'b0;
	end

	// interrupt status (write one to clear, set wins) and mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist_r <= '0; imask_r <= '0; irq_r <= 1'b0;
		end else begin
			for (int i = 0; i < EP_NUM; i++) begin
				if (wb_req && we_i && is_ist && sel_i[0] && dat_i[i])
					ist_r[i] <= 1'b0;
				if (wb_req && we_i && is_imask && sel_i[0])
					imask_r[i] <= dat_i[i];
				if (int_set && (tok_go ? tok_i.ep : ep_r) == 4'(i))
					ist_r[i] <= 1'b1;
			end
			irq_r <= |(ist_r & imask_r);
		end
	end

	// bus answer one cycle after the request, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_r <= 1'b0; rdat_r <= 32'h0;
		end else begin
			wb_ack_r <= wb_req;
			rdat_r <= 32'h0;
			if (wb_req && !we_i) begin
				if (is_mode)
					rdat_r <= {23'h0, stall_r[wb_ep[0 +: $clog2(EP_NUM)]],
						setup_r[wb_ep[0 +: $clog2(EP_NUM)]],
						in_r[wb_ep[0 +: $clog2(EP_NUM)]],
						out_r[wb_ep[0 +: $clog2(EP_NUM)]],
						ack_r[wb_ep[0 +: $clog2(EP_NUM)]],
						mode_r[wb_ep[0 +: $clog2(EP_NUM)]]};
				else if (is_cnt)
					rdat_r <= {24'h0, data_toggle_flag_r[wb_ep[0 +: $clog2(EP_NUM)]],
						dval_r[wb_ep[0 +: $clog2(EP_NUM)]],
						cnt_r[wb_ep[0 +: $clog2(EP_NUM)]][5:0]};
				else if (is_ist)
					rdat_r <= 32'(ist_r);
				else if (is_imask)
					rdat_r <= 32'(imask_r);
			end
		end
	end

	assign ack_o      = wb_ack_r;
	assign dat_o      = rdat_r;
	assign resp_stb_o = resp_stb_r;
	assign resp_o     = resp_r;
	assign irq_o      = irq_r;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_setup_ok;
		st_r == UERE_ST_DATA && pid_r == UERE_PID_SETUP && data_end_i &&
			dvalid && ep_r == 4'h0;
	endsequence
	a_bad_tok_silent: assert property (tok_stb_i && !tok_i.ok &&
		st_r == UERE_ST_IDLE |=> !resp_stb_o)
		else $error("response to invalid token");
	a_irq_on_nak: assert property (tok_go && tok_i.pid == UERE_PID_IN &&
		m == 4'h1 |=> ist_r[ep_r[0]])
		else $error("nak in did not raise interrupt");
	a_crc_bad_irq: assert property (st_r == UERE_ST_DATA && data_end_i &&
		(pid_r == UERE_PID_SETUP || m == 4'h5 || m == 4'h9 || m == 4'hb) &&
		!dat_rx_i.crc_ok |=> ist_r[ep_r[0]])
		else $error("bad crc setup without interrupt");
	a_oversize_ign: assert property (st_r == UERE_ST_DATA && data_end_i &&
		32'(dat_rx_i.cnt) > MAX_CNT |=> !resp_stb_o)
		else $error("oversize packet answered");
	a_in_on_out_ep: assert property (tok_go && tok_i.pid == UERE_PID_IN &&
		m == 4'h8 |=> !resp_stb_o)
		else $error("in token answered by out endpoint");
	a_setup_mode: assert property (s_setup_ok |=> mode_r[0] == 4'h1 &&
		lock_r && resp_o.code == UERE_R_ACK)
		else $error("setup did not ack and go to nak mode");
	a_setup_early: assert property (st_r == UERE_ST_DATA &&
		pid_r == UERE_PID_SETUP && data_start_i |=> setup_r[ep_r[0]])
		else $error("setup flag late");
	a_lock_holds: assert property (lock_r && !(wb_req && !we_i) && !ep0_upd
		|=> lock_r)
		else $error("lock released without a read");
	a_lock_blocks: assert property (lock_r && wb_req && we_i && is_mode &&
		wb_ep == 4'h0 |=> $stable(mode_r[0]) || $past(upd))
		else $error("locked mode register written");
	a_busy_bound: assert property (busy_cnt_r < LOCK_CYC)
		else $error("transaction window too long");
	a_status_chk: assert property (st_r == UERE_ST_DATA && data_end_i &&
		pid_r == UERE_PID_OUT && m == 4'h2 && dvalid && !dat_rx_i.tog
		|=> resp_o.code == UERE_R_STALL && resp_stb_o)
		else $error("status check did not stall");
	a_ack_fallback: assert property (st_r == UERE_ST_DATA && data_end_i &&
		pid_r == UERE_PID_OUT && m == 4'hb && dvalid
		|=> mode_r[ep_r[0]] == 4'ha)
		else $error("ack mode did not fall back");
	a_tx0_zero: assert property (tok_go && tok_i.pid == UERE_PID_IN &&
		m == 4'h6 |=> resp_stb_o && resp_o.cnt == 7'h00)
		else $error("status in did not send zero length");
	a_sio_stall: assert property (st_r == UERE_ST_DATA && data_end_i &&
		pid_r == UERE_PID_OUT && m == 4'h6 && dvalid
		|=> mode_r[ep_r[0]] == 4'h3 ##0 out_r[ep_r[0]])
		else $error("status in only did not stall out");
endmodule

// File: hdl/uere_cfg.svh
// register map, field positions, reset values and timing counts
`ifndef UERE_CFG_SVH
`define UERE_CFG_SVH
`define UERE_MODE_OFS    8'h00
`define UERE_COUNT_OFS   8'h04
`define UERE_EP_STRIDE   8'h08
`define UERE_INT_STAT    8'h40
`define UERE_INT_MASK    8'h44
`define UERE_F_MODE_LO   0
`define UERE_F_ACK       4
`define UERE_F_OUT       5
`define UERE_F_IN        6
`define UERE_F_SETUP     7
`define UERE_F_STALL     8
`define UERE_F_DVAL      6
`define UERE_F_DATA_TOGGLE_FLAG      7
`define UERE_MODE_RST    4'h0
`define UERE_MODE_NAKIO  4'h1
`define UERE_MODE_STALL  4'h3
`define UERE_CRC_BYTES   2
`define UERE_ZLP_COUNT   2
`define UERE_CLK_NS      10
`define UERE_LOCK_NS     1000
`define UERE_LOCK_CYC    (`UERE_LOCK_NS / `UERE_CLK_NS)
`endif

// File: hdl/uere_pkg.sv
// types shared by the endpoint response engine and its bench
package uere_pkg;
	typedef enum logic [1:0] {
		UERE_PID_OUT   = 2'h0,
		UERE_PID_IN    = 2'h1,
		UERE_PID_SETUP = 2'h2
	} uere_pid_e;
	typedef enum logic [2:0] {
		UERE_R_NONE  = 3'h0,
		UERE_R_ACK   = 3'h1,
		UERE_R_NAK   = 3'h2,
		UERE_R_STALL = 3'h3,
		UERE_R_TX0   = 3'h4,
		UERE_R_TXCNT = 3'h5
	} uere_resp_e;
	typedef enum logic [1:0] {
		UERE_ST_IDLE = 2'b00,
		UERE_ST_DATA = 2'b01,
		UERE_ST_HS   = 2'b11
	} uere_state_e;
	typedef struct packed {
		uere_pid_e  pid;
		logic [3:0] ep;
		logic       ok;
	} uere_tok_s;
	typedef struct packed {
		logic [6:0] cnt;
		logic       crc_ok;
		logic       err_ok;
		logic       tog;
	} uere_dat_s;
	typedef struct packed {
		uere_resp_e code;
		logic [6:0] cnt;
		logic       tog;
	} uere_resp_s;
endpackage

// File: bench/uere_host_model.sv
// host side model: drives decoded token and data phase events
`timescale 1ns/100ps
module uere_host_model import uere_pkg::*; (
	// clock
	input  wire logic clk_i,
	// decoded link events
	output logic      tok_stb_o,
	output uere_tok_s tok_o,
	output logic      data_start_o,
	output logic      data_end_o,
	output uere_dat_s dat_rx_o,
	output logic      in_end_o,
	output logic      in_ack_o
);
	// idle levels at time zero
	initial begin
		tok_stb_o = 1'b0;
		tok_o = '0;
		data_start_o = 1'b0;
		data_end_o = 1'b0;
		dat_rx_o = '0;
		in_end_o = 1'b0;
		in_ack_o = 1'b0;
	end
	// token pulse; fields inverted after it so no stale value stays
	task automatic tok(input uere_pid_e p, input logic [3:0] e,
		input logic ok);
		@(posedge clk_i);
		tok_stb_o <= 1'b1;
		tok_o <= '{p, e, ok};
		@(posedge clk_i);
		tok_stb_o <= 1'b0;
		tok_o <= uere_tok_s'(~{p, e, ok});
	endtask
	// start of the data packet
	task automatic dstart();
		@(posedge clk_i);
		data_start_o <= 1'b1;
		@(posedge clk_i);
		data_start_o <= 1'b0;
	endtask
	// end of the data packet with its checks
	task automatic dend(input uere_dat_s d);
		@(posedge clk_i);
		data_end_o <= 1'b1;
		dat_rx_o <= d;
		@(posedge clk_i);
		data_end_o <= 1'b0;
		dat_rx_o <= ~d;
	endtask
	// end of an in data phase, a = host handshake
	task automatic inend(input logic a);
		@(posedge clk_i);
		in_end_o <= 1'b1;
		in_ack_o <= a;
		@(posedge clk_i);
		in_end_o <= 1'b0;
		in_ack_o <= ~a;
	endtask
endmodule

// File: bench/uere_engine_tb.sv
// self-checking bench for the endpoint response engine
`timescale 1ns/100ps
module uere_engine_tb import uere_pkg::*;;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        tok_stb;
	uere_tok_s   tok;
	logic        dst;
	logic        dnd;
	uere_dat_s   drx;
	logic        iend;
	logic        iack;
	logic        rstb;
	uere_resp_s  resp;
	logic        irq;
	int          mismatches;
	int          checks;
	int          t;
	logic [31:0] rd_q[$];
	logic [31:0] mk_q[$];
	uere_resp_e  rs_q[$];
	uere_resp_e  in_tab[16] = '{UERE_R_NONE, UERE_R_NAK, UERE_R_STALL,
		UERE_R_STALL, UERE_R_NONE, UERE_R_NONE, UERE_R_TX0, UERE_R_TXCNT,
		UERE_R_NONE, UERE_R_NONE, UERE_R_TX0, UERE_R_TX0, UERE_R_NAK,
		UERE_R_TXCNT, UERE_R_NAK, UERE_R_TXCNT};

	uere_engine #(.EP_NUM(2), .EP_SIZE(8)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .tok_stb_i(tok_stb), .tok_i(tok),
		.data_start_i(dst), .data_end_i(dnd), .dat_rx_i(drx),
		.in_end_i(iend), .in_ack_i(iack), .resp_stb_o(rstb),
		.resp_o(resp), .irq_o(irq));
	uere_host_model i_host (
		.clk_i(clk_i), .tok_stb_o(tok_stb), .tok_o(tok),
		.data_start_o(dst), .data_end_o(dnd), .dat_rx_o(drx),
		.in_end_o(iend), .in_ack_o(iack));

	// 100 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic test_done();
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// classic single wishbone cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			test_done();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	// read; expected value and mask noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		rd_q.push_back(e);
		mk_q.push_back(m);
		bus(1'b0, a, ~e);
	endtask
	// every noted response must have appeared by now
	task automatic settle();
		repeat (3) @(posedge clk_i);
		cmp(32'h0, 32'(rs_q.size()));
	endtask
	task automatic chk_irq(input logic e);
		cmp({31'h0, e}, {31'h0, irq});
	endtask
	task automatic clr();
		wr(8'h40, 32'h3);
		repeat (2) @(posedge clk_i);
		chk_irq(1'b0);
	endtask
	task automatic xfer(input uere_pid_e p, input logic [3:0] e,
		input uere_dat_s d, input uere_resp_e r);
		if (r != UERE_R_NONE)
			rs_q.push_back(r);
		i_host.tok(p, e, 1'b1);
		i_host.dstart();
		i_host.dend(d);
		settle();
	endtask
	task automatic tx_in(input logic [3:0] e, input uere_resp_e r,
		input logic w);
		if (r != UERE_R_NONE)
			rs_q.push_back(r);
		i_host.tok(UERE_PID_IN, e, 1'b1);
		if (w)
			i_host.inend(1'b1);
		settle();
	endtask
	// read data monitor: compares at the ack edge
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
			cmp(rd_q.pop_front(), rdat & mk_q.pop_front());
	end
	// response monitor: an unnoted pulse compares against zero
	always @(posedge clk_i) begin
		if (rstb === 1'b1) begin
			if (rs_q.size() == 0)
				cmp(32'h0, 32'(resp.code));
			else
				cmp(32'(rs_q.pop_front()), 32'(resp.code));
		end
	end
	// main sequence
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		mismatches = 0;
		checks = 0;
		t = $urandom(64427);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h00, 32'h0, 32'h1ff);
		rd(8'h08, 32'h0, 32'h1ff);
		tx_in(4'h1, UERE_R_NONE, 1'b0);
		wr(8'h44, 32'h3);
		// out accepted at the size boundary, random toggle
		t = $urandom() % 2;
		wr(8'h08, 32'hb);
		rs_q.push_back(UERE_R_ACK);
		i_host.tok(UERE_PID_OUT, 4'h1, 1'b1);
		i_host.dstart();
		rd(8'h08, 32'h0, 32'h20);
		i_host.dend('{7'd10, 1'b1, 1'b1, t[0]});
		settle();
		chk_irq(1'b1);
		rd(8'h08, 32'h3a, 32'h3f);
		rd(8'h0c, {24'h0, t[0], 7'h4a}, 32'hff);
		clr();
		xfer(UERE_PID_OUT, 4'h1, '{7'd4, 1'b1, 1'b1, 1'b0}, UERE_R_NAK);
		chk_irq(1'b1);
		clr();
		// oversize and bad crc are dropped but still interrupt
		wr(8'h08, 32'hb);
		xfer(UERE_PID_OUT, 4'h1, '{7'd11, 1'b1, 1'b1, 1'b0}, UERE_R_NONE);
		chk_irq(1'b1);
		clr();
		xfer(UERE_PID_OUT, 4'h1, '{7'd4, 1'b0, 1'b1, 1'b0}, UERE_R_NONE);
		chk_irq(1'b1);
		rd(8'h08, 32'hb, 32'hf);
		rd(8'h0c, 32'h0, 32'h40);
		clr();
		// status check and status-in-only out handling
		wr(8'h08, 32'h2);
		xfer(UERE_PID_OUT, 4'h1, '{7'd2, 1'b1, 1'b1, 1'b1}, UERE_R_ACK);
		rd(8'h08, 32'h2, 32'hf);
		xfer(UERE_PID_OUT, 4'h1, '{7'd2, 1'b1, 1'b1, 1'b0}, UERE_R_STALL);
		rd(8'h08, 32'h3, 32'hf);
		wr(8'h08, 32'h6);
		xfer(UERE_PID_OUT, 4'h1, '{7'd2, 1'b1, 1'b1, 1'b1}, UERE_R_STALL);
		rd(8'h08, 32'h23, 32'h2f);
		wr(8'h08, 32'hc);
		xfer(UERE_PID_OUT, 4'h1, '{7'd2, 1'b1, 1'b1, 1'b1}, UERE_R_NONE);
		// in response of every mode
		for (int m = 0; m < 16; m++) begin
			wr(8'h08, 32'(m));
			tx_in(4'h1, in_tab[m], (in_tab[m] == UERE_R_TX0 ||
				in_tab[m] == UERE_R_TXCNT) && m != 7);
		end
		wr(8'h08, 32'h10d);
		tx_in(4'h1, UERE_R_STALL, 1'b0);
		wr(8'h08, 32'h6);
		tx_in(4'h1, UERE_R_TX0, 1'b1);
		rd(8'h08, 32'h56, 32'h5f);
		clr();
		// invalid tokens, then a masked interrupt
		wr(8'h08, 32'h1);
		i_host.tok(UERE_PID_IN, 4'h1, 1'b0);
		i_host.tok(UERE_PID_IN, 4'h2, 1'b1);
		settle();
		chk_irq(1'b0);
		wr(8'h44, 32'h0);
		tx_in(4'h1, UERE_R_NAK, 1'b0);
		chk_irq(1'b0);
		wr(8'h44, 32'h3);
		repeat (2) @(posedge clk_i);
		chk_irq(1'b1);
		clr();
		// setup on endpoint 0, then the write lock
		wr(8'h00, 32'h3);
		rs_q.push_back(UERE_R_ACK);
		i_host.tok(UERE_PID_SETUP, 4'h0, 1'b1);
		rd(8'h00, 32'h0, 32'h80);
		i_host.dstart();
		rd(8'h00, 32'h80, 32'h80);
		i_host.dend('{7'd10, 1'b1, 1'b1, 1'b0});
		settle();
		wr(8'h00, 32'h3);
		wr(8'h04, 32'h5);
		rd(8'h04, 32'h0a, 32'h3f);
		rd(8'h00, 32'h1, 32'hf);
		wr(8'h00, 32'h3);
		rd(8'h00, 32'h3, 32'hf);
		// endpoint 0 write refused in flight, watchdog frees it
		i_host.tok(UERE_PID_SETUP, 4'h0, 1'b1);
		wr(8'h00, 32'h1);
		repeat (110) @(posedge clk_i);
		rd(8'h00, 32'h3, 32'hf);
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h1, 32'hf);
		rd(8'h80, 32'h0, 32'hffffffff);
		test_done();
	end
endmodule
